// *** pnc_pkg.sv ***
// Package of types, constants and helper functions for the peak noise canceller.
// Notes on behaviour
// - Highpass the audio stream and compare its magnitude with the core threshold.
// - A highpass magnitude above threshold triggers a sample replacement run.
// - Remove the 19 kHz pilot before the detection highpass.
// - Delay audio by a programmable amount so replacement hits the peak.
// - Replace corrupted samples by the mean of clean neighbours; pass others unchanged.
// - Each trigger replaces a run of zero to fifteen samples, four-bit setting.
// - Detection, delay and replacement all step at the 228 kHz sample rate.
`default_nettype none

package pnc_pkg;

  // ==========================================================================
  // Widths and depths
  localparam int SMP_W     = 16;
  localparam int DLY_W     = 5;
  localparam int DEPTH     = 32;
  localparam int RUN_W     = 4;
  localparam int NOTCH_LAG = 6;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ        = 25000000;
  localparam int SMP_RATE_HZ   = 228000;
  localparam int PILOT_HZ      = 19000;
  // Clock cycles between two samples at the nominal rate (rounded down).
  localparam int SMP_PERIOD_CYC = CLK_HZ / SMP_RATE_HZ;

  // ==========================================================================
  // Reset values
  localparam logic [SMP_W-1:0] SMP_RST = 16'h0000;
  localparam logic [RUN_W-1:0] CNT_RST = 4'h0;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic                    valid;
    logic signed [SMP_W-1:0] data;
  } pnc_sample_type;

  typedef struct packed {
    logic [SMP_W-1:0] threshold;
    logic [DLY_W-1:0] delay;
    logic [RUN_W-1:0] run_len;
  } pnc_cfg_type;

  // ==========================================================================
  // Arithmetic helpers
  function automatic logic [SMP_W+1:0] pnc_abs(input logic signed [SMP_W+1:0] v);
    pnc_abs = v[SMP_W+1] ? $unsigned(-v) : $unsigned(v);
  endfunction : pnc_abs

  function automatic logic signed [SMP_W-1:0] pnc_mean(input logic signed [SMP_W-1:0] a,
                                                       input logic signed [SMP_W-1:0] b);
    logic signed [SMP_W:0] s;
    s = {a[SMP_W-1], a} + {b[SMP_W-1], b};
    pnc_mean = s[SMP_W:1];
  endfunction : pnc_mean

endpackage : pnc_pkg

`default_nettype wire

// *** pnc_detect.sv ***
// Pilot notch, highpass and threshold detector of the peak noise canceller.
`timescale 1ns/1ps
`default_nettype none

module pnc_detect
  import pnc_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           rst_n,
  input  wire pnc_sample_type in_smp,
  input  wire logic [SMP_W-1:0] threshold,
  output var  logic           hit_r
);

  // ==========================================================================
  // Pilot notch
  logic signed [SMP_W-1:0] lag_r [NOTCH_LAG];
  logic signed [SMP_W:0]   notch_r;
  logic signed [SMP_W:0]   notch_nxt;
  logic signed [SMP_W+1:0] hp_nxt;
  logic [SMP_W+1:0]        mag_r;
  logic                    chk_r;
  wire  logic              over_thr;

  // pilot comb notch
  // Adding the sample six steps back is half a pilot period at 228 kHz, so
  // 19 kHz and its odd harmonics cancel before the highpass sees them.
  assign notch_nxt = {in_smp.data[SMP_W-1], in_smp.data}
                   + {lag_r[NOTCH_LAG-1][SMP_W-1], lag_r[NOTCH_LAG-1]};
  assign hp_nxt    = {notch_nxt[SMP_W], notch_nxt} - {notch_r[SMP_W], notch_r};
  assign over_thr  = mag_r > {2'b00, threshold};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NOTCH_LAG; i++) begin
        lag_r[i] <= SMP_RST;
      end
      notch_r <= '0;
      mag_r   <= '0;
      chk_r   <= 1'b0;
      hit_r   <= 1'b0;
    end else begin
      chk_r <= in_smp.valid;
      hit_r <= chk_r & over_thr;
      if (in_smp.valid) begin
        lag_r[0] <= in_smp.data;
        for (int i = 1; i < NOTCH_LAG; i++) begin
          lag_r[i] <= lag_r[i-1];
        end
        notch_r <= notch_nxt;
        mag_r   <= pnc_abs(hp_nxt);
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_pilot_notch: assert property (in_smp.valid |=>
    notch_r == $past(notch_nxt) && lag_r[0] == $past(in_smp.data))
    else $error("pilot notch did not take the new sample");

  chk_thr_compare: assert property (chk_r |=> hit_r == $past(over_thr))
    else $error("threshold compare gave the wrong trigger");

  chk_hit_source: assert property (hit_r |-> $past(in_smp.valid, 2))
    else $error("trigger without a sample two cycles before");

endmodule : pnc_detect

`default_nettype wire

// *** pnc_top.sv ***
// Top of the peak noise canceller: audio delay line and replacement run logic.
`timescale 1ns/1ps
`default_nettype none

module pnc_top
  import pnc_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           rst_n,
  input  wire pnc_sample_type in_smp,
  input  wire pnc_cfg_type    cfg,
  output var  pnc_sample_type out_smp_r,
  output var  logic           trigger_r,
  output var  logic           run_busy_r
);

  // ==========================================================================
  // Detector
  logic det_hit;

  pnc_detect u_detect (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_smp    (in_smp),
    .threshold (cfg.threshold),
    .hit_r     (det_hit)
  );

  // ==========================================================================
  // Audio delay line and run state
  logic signed [SMP_W-1:0] line_r [DEPTH];
  logic                    mark_r [DEPTH];
  logic signed [SMP_W-1:0] before_r;
  logic signed [SMP_W-1:0] after_r;
  logic [RUN_W-1:0]        cnt_r;
  logic [RUN_W-1:0]        cnt_nxt;

  wire logic                    in_run;
  wire logic                    start_run;
  wire logic                    replace;
  wire logic signed [DLY_W:0]   idx_diff;
  wire logic [DLY_W-1:0]        after_idx;
  wire logic signed [SMP_W-1:0] tap;
  wire logic signed [SMP_W-1:0] after_cur;
  wire logic signed [SMP_W-1:0] mean_val;

  assign in_run    = cnt_r != CNT_RST;
  assign tap       = line_r[cfg.delay];
  // zero length means no run
  // A run starts when the marked peak sample reaches the tap, so the peak
  // itself is the first sample replaced.
  assign start_run = in_smp.valid && mark_r[cfg.delay] && (cfg.run_len != CNT_RST);
  assign replace   = in_smp.valid && (start_run || in_run);
  // first clean sample after the run
  // The sample just past the run sits run_len places newer than the tap.
  // If the delay is shorter than the run it is not yet in the line, so the
  // newest sample stands in; delay should be set no lower than run_len.
  assign idx_diff  = $signed({1'b0, cfg.delay}) - $signed({2'b00, cfg.run_len});
  assign after_idx = idx_diff[DLY_W] ? '0 : idx_diff[DLY_W-1:0];
  assign after_cur = start_run ? line_r[after_idx] : after_r;
  assign mean_val  = pnc_mean(before_r, after_cur);

  // retrigger restarts count
  // The starting sample is replaced at once, so the count holds the rest.
  assign cnt_nxt = start_run ? cfg.run_len - 4'h1 :
                   (in_smp.valid && in_run) ? cnt_r - 4'h1 : cnt_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        line_r[i] <= SMP_RST;
      end
    end else if (in_smp.valid) begin
      line_r[0] <= in_smp.data;
      for (int i = 1; i < DEPTH; i++) begin
        line_r[i] <= line_r[i-1];
      end
    end
  end

  // mark triggered sample
  // A hit belongs to the newest sample; if the next sample arrives in the
  // same cycle, the marked one has already moved one place down the line.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mark_r[i] <= 1'b0;
      end
    end else if (in_smp.valid) begin
      mark_r[0] <= 1'b0;
      mark_r[1] <= mark_r[0] | det_hit;
      for (int i = 2; i < DEPTH; i++) begin
        mark_r[i] <= mark_r[i-1];
      end
    end else if (det_hit) begin
      mark_r[0] <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r      <= CNT_RST;
      run_busy_r <= 1'b0;
      trigger_r  <= 1'b0;
    end else begin
      cnt_r      <= cnt_nxt;
      run_busy_r <= cnt_nxt != CNT_RST;
      trigger_r  <= det_hit;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      before_r <= SMP_RST;
      after_r  <= SMP_RST;
    end else begin
      if (start_run) begin
        after_r <= after_cur;
      end
      if (in_smp.valid && !replace) begin
        before_r <= tap;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_smp_r <= '0;
    end else begin
      out_smp_r.valid <= in_smp.valid;
      if (in_smp.valid) begin
        out_smp_r.data <= replace ? mean_val : tap;
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_hit_in_run;
    start_run && in_run;
  endsequence

  sequence s_clean_step;
    in_smp.valid && !replace;
  endsequence

  chk_out_step: assert property (in_smp.valid |=> out_smp_r.valid)
    else $error("output did not follow an input sample");

  chk_out_idle: assert property (!in_smp.valid |=> !out_smp_r.valid)
    else $error("output without an input sample");

  chk_delay_tap: assert property (s_clean_step |=>
    out_smp_r.data == $past(tap) && before_r == out_smp_r.data)
    else $error("clean output is not the delayed tap");

  chk_mean_out: assert property (replace |=>
    out_smp_r.data == pnc_mean($past(before_r), $past(after_cur)))
    else $error("replaced sample is not the neighbour mean");

  chk_run_load: assert property (start_run |=>
    cnt_r == $past(cfg.run_len) - 4'h1)
    else $error("run length not loaded on trigger");

  chk_zero_run: assert property ((in_smp.valid && cfg.run_len == CNT_RST && !in_run)
    |=> !run_busy_r)
    else $error("zero length setting started a run");

  chk_retrigger: assert property (s_hit_in_run |=>
    cnt_r == $past(cfg.run_len) - 4'h1 && before_r == $past(before_r))
    else $error("retrigger did not restart the run");

  chk_run_step: assert property ((in_smp.valid && in_run && !start_run) |=>
    cnt_r == $past(cnt_r) - 4'h1)
    else $error("run count did not step with the sample");

endmodule : pnc_top

`default_nettype wire

// *** pnc_dsp_model.sv ***
// Core-side model: forwards settings, feeds samples and reads back status.
`timescale 1ns/1ps
`default_nettype none

module pnc_dsp_model
  import pnc_pkg::*;
(
  input  wire logic           clock,
  input  wire pnc_sample_type out_smp_r,
  input  wire logic           trigger_r,
  input  wire logic           run_busy_r,
  output var  pnc_sample_type in_smp,
  output var  pnc_cfg_type    cfg
);
  initial begin
    in_smp = '0;
    cfg    = '0;
  end

  task automatic set_cfg(input logic [SMP_W-1:0] t, input logic [DLY_W-1:0] d,
                         input logic [RUN_W-1:0] n);
    @(posedge clock);
    #1;
    cfg = '{threshold: t, delay: d, run_len: n};
  endtask : set_cfg

  // one sample per period
  // Data is inverted once valid drops, so a stale value never looks right.
  task automatic put(input logic [SMP_W-1:0] d, input int gap, output pnc_sample_type o,
                     output logic [3:0] vld, output logic [3:0] trg, output logic busy);
    @(posedge clock);
    #1;
    in_smp = {1'b1, d};
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      #1;
      in_smp = {1'b0, ~d};
      vld[i] = out_smp_r.valid;
      trg[i] = trigger_r;
      if (i == 1) o = out_smp_r;
    end
    busy = run_busy_r;
    repeat (gap - 5) @(posedge clock);
  endtask : put
endmodule : pnc_dsp_model

`default_nettype wire

// *** test_fm_impulse_noise_canceller.sv ***
// Self-checking testbench of the peak noise canceller.
`timescale 1ns/1ps
`default_nettype none

module test_fm_impulse_noise_canceller
  import pnc_pkg::*;
;
  logic           clock;
  logic           rst_n;
  pnc_sample_type in_smp;
  pnc_cfg_type    cfg;
  pnc_sample_type out_smp_r;
  logic           trigger_r;
  logic           run_busy_r;
  pnc_sample_type o;
  logic [3:0]     v;
  logic [3:0]     t;
  logic           b;
  int             errors = 0;
  int             check_count = 0;

  pnc_top dut (.clock(clock), .rst_n(rst_n), .in_smp(in_smp), .cfg(cfg),
               .out_smp_r(out_smp_r), .trigger_r(trigger_r), .run_busy_r(run_busy_r));
  pnc_dsp_model m (.clock(clock), .out_smp_r(out_smp_r), .trigger_r(trigger_r),
                   .run_busy_r(run_busy_r), .in_smp(in_smp), .cfg(cfg));

  // ==========================================================================
  // Checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // Scenarios
  task automatic test_delay;
    int dl[3] = '{0, 7, 31};
    foreach (dl[k]) begin
      m.set_cfg(16'hffff, dl[k][4:0], 4'h0);
      for (int j = 0; j < 40; j++) begin
        m.put(16'h0100 + j[15:0], 5, o, v, t, b);
        check(v, 4'b0001);
        check(t, 4'h0);
        if (j > dl[k]) check(o.data, 16'h0100 + j - dl[k] - 1);
      end
    end
    $display("test_delay done");
  endtask : test_delay

  // A 12-sample square wave is the pilot at this sample rate.
  task automatic test_pilot;
    m.set_cfg(16'hffff, 5'h00, 4'hf);
    for (int j = 0; j < 36; j++) begin
      if (j == 12) m.set_cfg(16'h1000, 5'h00, 4'hf);
      m.put((j % 12 < 6) ? 16'h2000 : 16'he000, 5, o, v, t, b);
      if (j >= 12) check({t, b}, 5'h00);
    end
    $display("test_pilot done");
  endtask : test_pilot

  // Steps of exactly the threshold stay quiet, then one impulse fires; the
  // run starts when the peak reaches the tap sixteen samples later.
  task automatic test_run;
    m.set_cfg(16'hffff, 5'h0f, 4'hf);
    repeat (12) m.put(16'h0100, 5, o, v, t, b);
    m.set_cfg(16'h1000, 5'h0f, 4'hf);
    repeat (16) begin
      m.put(16'h1100, 5, o, v, t, b);
      check(t, 4'h0);
    end
    for (int j = 0; j < 41; j++) begin
      m.put((j == 0) ? 16'h5100 : 16'h1100, 5, o, v, t, b);
      check(t, (j inside {0, 1, 6, 7}) ? 4'b0100 : 4'b0000);
      check(o.data, 16'h1100);
      check(b, (j >= 16 && j < 37));
    end
    $display("test_run done");
  endtask : test_run

  task automatic test_zero_run;
    m.set_cfg(16'hffff, 5'h00, 4'h0);
    repeat (8) m.put(16'h1100, 5, o, v, t, b);
    m.set_cfg(16'h1000, 5'h00, 4'h0);
    m.put(16'h5100, 5, o, v, t, b);
    check({t, b}, 5'b01000);
    m.put(16'h1100, 5, o, v, t, b);
    check(o.data, 16'h5100);
    $display("test_zero_run done");
  endtask : test_zero_run

  // ==========================================================================
  // Clock, reset, sequence and watchdog
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check({out_smp_r, trigger_r, run_busy_r}, 19'h0);
    rst_n = 1'b1;
    test_delay();
    test_pilot();
    test_run();
    test_zero_run();
    report_and_stop();
  end

  // All scenarios need well under 2000 cycles; ten times that means a hang.
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    report_and_stop();
  end
endmodule : test_fm_impulse_noise_canceller

`default_nettype wire
